// ### rtl/srrc_core.sv
// Execution of subroutine return and rotate-left-through-carry
// Function
// - Return pops the call stack into the program counter; flags untouched when s is clear.
// - Return with s set restores accumulator, status and bank from shadows.
// - Return with s clear leaves accumulator, status and bank alone.
// - Return never changes the upper or high program counter latches.
// - Rotate shifts byte left; bit 7 to carry, old carry to bit 0.
// - Rotate with d clear writes the accumulator, not the file byte.
// - Rotate with d set writes the result back to the same byte.
// - Rotate with a clear addresses the access bank, ignoring bank select.
// - Rotate with a set takes the bank from the bank select register.
// - a clear, extended set on, address up to 5Fh: indexed offset mode.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module srrc_core
  import srrc_pkg::*;
#(
  parameter int PC_W = PC_W_DEF
)(
  input  wire logic               aclk,        // Core clock, 10 MHz
  input  wire logic               aresetn,     // Sync reset, low
  input  wire logic [7:0]         awaddr,      // AXI write address
  input  wire logic               awvalid,     // AXI write address valid
  output wire logic               awready,     // AXI write address ready
  input  wire logic [31:0]        wdata,       // AXI write data
  input  wire logic [3:0]         wstrb,       // AXI byte strobes
  input  wire logic               wvalid,      // AXI write data valid
  output wire logic               wready,      // AXI write data ready
  output wire logic [1:0]         bresp,       // AXI write response
  output wire logic               bvalid,      // AXI write response valid
  input  wire logic               bready,      // AXI write response ready
  input  wire logic [7:0]         araddr,      // AXI read address
  input  wire logic               arvalid,     // AXI read address valid
  output wire logic               arready,     // AXI read address ready
  output wire logic [31:0]        rdata,       // AXI read data
  output wire logic [1:0]         rresp,       // AXI read response
  output wire logic               rvalid,      // AXI read data valid
  input  wire logic               rready,      // AXI read data ready
  input  wire logic               instr_valid, // Fetched word present
  input  wire logic [15:0]        instr_word,  // Fetched instruction
  output wire logic               instr_ready, // Sequencer free
  input  wire logic [PC_W-1:0]    stack_top,   // Call stack top
  output wire logic               stack_pop,   // Pop strobe
  output logic      [PC_W-1:0]    pc,          // Program counter
  output logic      [MADDR_W-1:0] mem_addr,    // Data memory address
  output wire logic               mem_rd_en,   // Data memory read
  input  wire logic [7:0]         mem_rdata,   // Read data, next cycle
  output wire logic               mem_wr_en,   // Data memory write
  output logic      [7:0]         mem_wdata    // Write data
);
  if (PC_W < 8 || PC_W > 32)
  begin : g_bad_pc_w
    $error("PC_W must lie in 8..32");
  end

  srrc_state_e state;
  srrc_state_e next_state;
  logic [1:0]  q;
  logic        s_q;
  logic        d_q;
  logic        c_q;
  logic        sw_wr;
  logic        ext_en;
  logic [7:0]  accumulator;
  logic [7:0]  status;
  logic [7:0]  bank_select_reg;
  logic [7:0]  working_shadow;
  logic [7:0]  flags_shadow;
  logic [7:0]  bank_select_shadow;
  logic [7:0]  pc_upper_latch;
  logic [7:0]  pc_high_latch;
  logic [11:0] index_base;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [MADDR_W-1:0] resolve(
    input logic       a,
    input logic       ext,
    input logic [7:0] f,
    input logic [7:0] bank,
    input logic [11:0] base
  );
    logic [MADDR_W-1:0] r;
    if (a)
      r = {bank[3:0], f};
    else if (ext && f <= ACC_LIMIT)
      r = base + {4'h0, f};
    else if (f <= ACC_LIMIT)
      r = {BANK_LOW, f};
    else
      r = {BANK_HIGH, f};
    return r;
  endfunction

  function automatic logic [7:0] rlc_flags(
    input logic [7:0] st,
    input logic [7:0] res,
    input logic       c
  );
    logic [7:0] o;
    o        = st;
    o[C_BIT] = c;
    o[N_BIT] = res[7];
    o[Z_BIT] = (res == 8'h00);
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire accept  = instr_valid && instr_ready;
  wire is_ret  = instr_word[15:1] == OPC_RET;
  wire is_rlc  = instr_word[15:10] == OPC_RLC;
  wire unk_set = accept && !is_ret && !is_rlc;
  wire [MADDR_W-1:0] f_addr = resolve(instr_word[BIT_A], ext_en,
                                      instr_word[7:0], bank_select_reg,
                                      index_base);
  wire pop     = state == ST_RET && q == Q_LAST;
  wire calc    = state == ST_RLC && q == Q_CALC;
  wire wb      = state == ST_RLC && q == Q_LAST;
  wire [7:0] rot = {mem_rdata[6:0], status[C_BIT]};

  assign instr_ready = state == ST_IDLE;
  assign stack_pop   = pop;
  assign mem_rd_en   = state == ST_RLC && q == Q_READ;
  assign mem_wr_en   = wb && d_q;

  // ----------------------------------------------------------------
  // Register updates handed to the register file
  // ----------------------------------------------------------------
  wire upd_acc_en  = (wb && !d_q) || (pop && s_q);
  wire [7:0] upd_acc = pop ? working_shadow : mem_wdata;
  wire upd_stat_en = wb || (pop && s_q);
  wire [7:0] upd_stat = pop ? flags_shadow
                            : rlc_flags(status, mem_wdata, c_q);
  wire upd_bank_en = pop && s_q;

  // ----------------------------------------------------------------
  // Sequencer: four clocks per instruction cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (accept && is_ret)
          next_state = ST_RET;
        else if (accept && is_rlc)
          next_state = ST_RLC;
      ST_RLC:
        if (q == Q_LAST)
          next_state = ST_IDLE;
      ST_RET:
        if (q == Q_LAST)
          next_state = ST_NOP;
      ST_NOP:
        if (q == Q_LAST)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_IDLE;
      q     <= 2'h0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE)
        q <= accept ? Q_READ : 2'h0;
      else
        q <= q + 2'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q      <= 1'b0;
      d_q      <= 1'b0;
      mem_addr <= '0;
    end
    else if (accept)
    begin
      s_q      <= instr_word[BIT_S];
      d_q      <= instr_word[BIT_D];
      mem_addr <= f_addr;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_wdata <= 8'h00;
      c_q       <= 1'b0;
    end
    else if (calc)
    begin
      mem_wdata <= rot;
      c_q       <= mem_rdata[7];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pc <= '0;
    else if (pop)
      pc <= stack_top;
  end

  // ----------------------------------------------------------------
  // Register file and bus slave
  // ----------------------------------------------------------------
  srrc_regs #(
    .PC_W (PC_W)
  ) u_regs (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .awaddr             (awaddr),
    .awvalid            (awvalid),
    .awready            (awready),
    .wdata              (wdata),
    .wstrb              (wstrb),
    .wvalid             (wvalid),
    .wready             (wready),
    .bresp              (bresp),
    .bvalid             (bvalid),
    .bready             (bready),
    .araddr             (araddr),
    .arvalid            (arvalid),
    .arready            (arready),
    .rdata              (rdata),
    .rresp              (rresp),
    .rvalid             (rvalid),
    .rready             (rready),
    .upd_acc_en         (upd_acc_en),
    .upd_acc            (upd_acc),
    .upd_stat_en        (upd_stat_en),
    .upd_stat           (upd_stat),
    .upd_bank_en        (upd_bank_en),
    .upd_bank           (bank_select_shadow),
    .unk_set            (unk_set),
    .pc_in              (pc),
    .state_in           (state),
    .sw_wr              (sw_wr),
    .ext_en             (ext_en),
    .accumulator        (accumulator),
    .status             (status),
    .bank_select_reg    (bank_select_reg),
    .working_shadow     (working_shadow),
    .flags_shadow       (flags_shadow),
    .bank_select_shadow (bank_select_shadow),
    .pc_upper_latch     (pc_upper_latch),
    .pc_high_latch      (pc_high_latch),
    .index_base         (index_base)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ret_pc_load: assert property (
    pop |=> pc == $past(stack_top))
    else $error("pc not loaded from stack top");

  a_ret_shadow: assert property (
    pop && s_q && !sw_wr |=> accumulator == $past(working_shadow)
      && status == $past(flags_shadow)
      && bank_select_reg == $past(bank_select_shadow))
    else $error("shadow restore wrong");

  a_ret_keep: assert property (
    pop && !s_q && !sw_wr |=> $stable(accumulator) && $stable(status)
      && $stable(bank_select_reg))
    else $error("return without s changed registers");

  a_latch_keep: assert property (
    accept && is_ret ##1 !sw_wr [*3] |=> $stable(pc_upper_latch)
      && $stable(pc_high_latch))
    else $error("pc latches changed by return");

  a_rot_carry: assert property (
    mem_rd_en ##1 !sw_wr ##1 !sw_wr |=> status[C_BIT] == $past(mem_rdata[7], 2)
      && mem_wdata == {$past(mem_rdata[6:0], 2), $past(status[C_BIT], 2)})
    else $error("rotate through carry wrong");

  a_rot_to_acc: assert property (
    wb && !d_q && !sw_wr |-> !mem_wr_en ##1 accumulator == $past(mem_wdata))
    else $error("rotate to accumulator wrong");

  a_rot_to_file: assert property (
    wb && d_q |-> mem_wr_en && mem_addr == $past(mem_addr, 2))
    else $error("rotate write-back wrong");

  a_access_bank: assert property (
    accept && is_rlc && !instr_word[BIT_A]
      && !(ext_en && instr_word[7:0] <= ACC_LIMIT)
    |=> mem_addr[11:8] == (mem_addr[7:0] <= ACC_LIMIT ? BANK_LOW : BANK_HIGH)
      && mem_addr[7:0] == $past(instr_word[7:0]))
    else $error("access bank address wrong");

  a_bank_sel: assert property (
    accept && is_rlc && instr_word[BIT_A]
    |=> mem_addr == {$past(bank_select_reg[3:0]), $past(instr_word[7:0])})
    else $error("banked address wrong");

  a_indexed: assert property (
    accept && is_rlc && !instr_word[BIT_A] && ext_en
      && instr_word[7:0] <= ACC_LIMIT
    |=> mem_addr == 12'($past(index_base) + {4'h0, $past(instr_word[7:0])}))
    else $error("indexed offset address wrong");

  a_rlc_len: assert property (
    accept && is_rlc |=> !instr_ready [*3] ##1 instr_ready)
    else $error("rotate length wrong");

  a_ret_len: assert property (
    accept && is_ret |-> ##3 stack_pop ##1 !instr_ready [*4] ##1 instr_ready)
    else $error("return length wrong");

  a_flag_nz: assert property (
    wb && !sw_wr |=> status[N_BIT] == $past(mem_wdata[7])
      && status[Z_BIT] == ($past(mem_wdata) == 8'h00))
    else $error("negative or zero flag wrong");
endmodule // srrc_core

// ### rtl/srrc_pkg.sv
// Package: constants for subroutine return and rotate-through-carry execution
package srrc_pkg;
  localparam int          PC_W_DEF    = 21;
  localparam int          MADDR_W     = 12;
  localparam int          RADDR_W     = 8;
  // Opcode patterns
  localparam logic [14:0] OPC_RET     = 15'h0009;
  localparam logic [5:0]  OPC_RLC     = 6'h0D;
  localparam int          BIT_S       = 0;
  localparam int          BIT_A       = 8;
  localparam int          BIT_D       = 9;
  // File address resolution
  localparam logic [7:0]  ACC_LIMIT   = 8'h5F;
  localparam logic [3:0]  BANK_LOW    = 4'h0;
  localparam logic [3:0]  BANK_HIGH   = 4'hF;
  // Status flag positions
  localparam int          C_BIT       = 0;
  localparam int          Z_BIT       = 2;
  localparam int          N_BIT       = 4;
  // Clock phases inside one instruction cycle
  localparam logic [1:0]  Q_READ      = 2'h1;
  localparam logic [1:0]  Q_CALC      = 2'h2;
  localparam logic [1:0]  Q_LAST      = 2'h3;
  // Register byte offsets
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_ACC     = 8'h04;
  localparam logic [7:0]  REG_STATUS  = 8'h08;
  localparam logic [7:0]  REG_BANK    = 8'h0C;
  localparam logic [7:0]  REG_WSHAD   = 8'h10;
  localparam logic [7:0]  REG_FSHAD   = 8'h14;
  localparam logic [7:0]  REG_BSHAD   = 8'h18;
  localparam logic [7:0]  REG_PCU     = 8'h1C;
  localparam logic [7:0]  REG_PCH     = 8'h20;
  localparam logic [7:0]  REG_IBASE   = 8'h24;
  localparam logic [7:0]  REG_PC      = 8'h28;
  localparam logic [7:0]  REG_INFO    = 8'h2C;
  localparam int          CTRL_EXT    = 0;
  localparam int          INFO_UNK    = 8;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [11:0] RST_IBASE   = 12'h000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RLC  = 4'b0010,
    ST_RET  = 4'b0100,
    ST_NOP  = 4'b1000
  } srrc_state_e;
endpackage

// ### rtl/srrc_regs.sv
// Register file with AXI4-Lite slave for the return/rotate execution block
`timescale 1ns/1ps
module srrc_regs
  import srrc_pkg::*;
#(
  parameter int PC_W = PC_W_DEF
)(
  input  wire logic               aclk,        // Core clock
  input  wire logic               aresetn,     // Sync reset, low
  input  wire logic [7:0]         awaddr,      // Write address
  input  wire logic               awvalid,     // Write address valid
  output wire logic               awready,     // Write address ready
  input  wire logic [31:0]        wdata,       // Write data
  input  wire logic [3:0]         wstrb,       // Byte strobes
  input  wire logic               wvalid,      // Write data valid
  output wire logic               wready,      // Write data ready
  output logic      [1:0]         bresp,       // Write response
  output logic                    bvalid,      // Write response valid
  input  wire logic               bready,      // Write response ready
  input  wire logic [7:0]         araddr,      // Read address
  input  wire logic               arvalid,     // Read address valid
  output wire logic               arready,     // Read address ready
  output logic      [31:0]        rdata,       // Read data
  output logic      [1:0]         rresp,       // Read response
  output logic                    rvalid,      // Read data valid
  input  wire logic               rready,      // Read data ready
  input  wire logic               upd_acc_en,  // Core writes accumulator
  input  wire logic [7:0]         upd_acc,     // New accumulator
  input  wire logic               upd_stat_en, // Core writes status
  input  wire logic [7:0]         upd_stat,    // New status
  input  wire logic               upd_bank_en, // Core writes bank select
  input  wire logic [7:0]         upd_bank,    // New bank select
  input  wire logic               unk_set,     // Unknown opcode seen
  input  wire logic [PC_W-1:0]    pc_in,       // Program counter
  input  wire logic [3:0]         state_in,    // Sequencer state
  output wire logic               sw_wr,       // Software write this cycle
  output logic                    ext_en,      // Extended set enabled
  output logic      [7:0]         accumulator, // Working register
  output logic      [7:0]         status,      // Status flags
  output logic      [7:0]         bank_select_reg, // Bank select
  output logic      [7:0]         working_shadow,  // Shadow of accumulator
  output logic      [7:0]         flags_shadow,    // Shadow of status
  output logic      [7:0]         bank_select_shadow, // Shadow of bank
  output logic      [7:0]         pc_upper_latch,  // PC upper latch
  output logic      [7:0]         pc_high_latch,   // PC high latch
  output logic      [11:0]        index_base       // Indexed offset base
);
  logic        aw_held;
  logic        w_held;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  wsb;
  logic        unk;
  logic [31:0] rd_word;
  logic        rd_err;
  logic        wr_err;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign sw_wr   = aw_held && w_held && !bvalid;
  wire   lo      = sw_wr && wsb[0];
  wire   hi      = sw_wr && wsb[1];

  always_comb
  begin
    case (wa)
      REG_CTRL, REG_ACC, REG_STATUS, REG_BANK, REG_WSHAD, REG_FSHAD,
      REG_BSHAD, REG_PCU, REG_PCH, REG_IBASE, REG_INFO: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wa      <= 8'h00;
      wd      <= 32'h0000_0000;
      wsb     <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        wa      <= awaddr;
      end
      else if (sw_wr)
        aw_held <= 1'b0;
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        wd     <= wdata;
        wsb    <= wstrb;
      end
      else if (sw_wr)
        w_held <= 1'b0;
      if (sw_wr)
      begin
        bvalid <= 1'b1;
        bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers; core updates win over software writes
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_en <= 1'b0;
      accumulator <= RST_BYTE;
      status <= RST_BYTE;
      bank_select_reg <= RST_BYTE;
      working_shadow <= RST_BYTE;
      flags_shadow <= RST_BYTE;
      bank_select_shadow <= RST_BYTE;
      pc_upper_latch <= RST_BYTE;
      pc_high_latch <= RST_BYTE;
      index_base <= RST_IBASE;
      unk <= 1'b0;
    end
    else
    begin
      if (lo && wa == REG_CTRL) ext_en <= wd[CTRL_EXT];
      if (upd_acc_en) accumulator <= upd_acc;
      else if (lo && wa == REG_ACC) accumulator <= wd[7:0];
      if (upd_stat_en) status <= upd_stat;
      else if (lo && wa == REG_STATUS) status <= wd[7:0];
      if (upd_bank_en) bank_select_reg <= upd_bank;
      else if (lo && wa == REG_BANK) bank_select_reg <= wd[7:0];
      if (lo && wa == REG_WSHAD) working_shadow <= wd[7:0];
      if (lo && wa == REG_FSHAD) flags_shadow <= wd[7:0];
      if (lo && wa == REG_BSHAD) bank_select_shadow <= wd[7:0];
      if (lo && wa == REG_PCU) pc_upper_latch <= wd[7:0];
      if (lo && wa == REG_PCH) pc_high_latch <= wd[7:0];
      if (lo && wa == REG_IBASE) index_base[7:0] <= wd[7:0];
      if (hi && wa == REG_IBASE) index_base[11:8] <= wd[11:8];
      // Set wins over write-one-to-clear
      if (unk_set) unk <= 1'b1;
      else if (hi && wa == REG_INFO && wd[INFO_UNK]) unk <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign arready = !rvalid;

  always_comb
  begin
    rd_err  = 1'b0;
    rd_word = 32'h0000_0000;
    case (araddr)
      REG_CTRL:   rd_word[CTRL_EXT] = ext_en;
      REG_ACC:    rd_word[7:0] = accumulator;
      REG_STATUS: rd_word[7:0] = status;
      REG_BANK:   rd_word[7:0] = bank_select_reg;
      REG_WSHAD:  rd_word[7:0] = working_shadow;
      REG_FSHAD:  rd_word[7:0] = flags_shadow;
      REG_BSHAD:  rd_word[7:0] = bank_select_shadow;
      REG_PCU:    rd_word[7:0] = pc_upper_latch;
      REG_PCH:    rd_word[7:0] = pc_high_latch;
      REG_IBASE:  rd_word[11:0] = index_base;
      REG_PC:     rd_word[PC_W-1:0] = pc_in;
      REG_INFO:
      begin
        rd_word[3:0]     = state_in;
        rd_word[INFO_UNK] = unk;
      end
      default:    rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule // srrc_regs

// ### tb/srrc_partner.sv
// Data memory and call stack model facing the core
`timescale 1ns/1ps
module srrc_partner
  import srrc_pkg::*;
(
  input  wire logic [MADDR_W-1:0]  mem_addr,  // File address
  input  wire logic                aclk,      // Core clock
  input  wire logic                mem_rd_en, // Read strobe
  output logic      [7:0]          mem_rdata, // Read data
  input  wire logic                mem_wr_en, // Write strobe
  input  wire logic [7:0]          mem_wdata, // Write data
  input  wire logic                stack_pop, // Pop strobe
  output logic      [PC_W_DEF-1:0] stack_top  // Stack top
);
  logic [7:0]          mem [0:4095];
  logic [PC_W_DEF-1:0] stk [0:1];
  logic                sp = 1'b0;
  initial mem_rdata = 8'h00;
  assign stack_top = stk[sp];
  always @(posedge aclk)
  begin
    // Stale read data is scrambled
    mem_rdata <= mem_rd_en ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr_en)
      mem[mem_addr] <= mem_wdata;
    if (stack_pop)
      sp <= ~sp;
  end
endmodule // srrc_partner

// ### tb/subroutine_return_and_rotate_carry_tb.sv
// Self-checking bench for the return and rotate execution block
`timescale 1ns/1ps
`define chk(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t got %h want %h", $time, g, e); end end
module subroutine_return_and_rotate_carry_tb;
  import srrc_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, instr_valid = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hF;
  logic [15:0] instr_word = 0;
  wire awready, wready, bvalid, arready, rvalid, instr_ready, stack_pop, mem_rd_en, mem_wr_en;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [20:0] pc, stack_top;
  wire [11:0] mem_addr;
  wire [7:0] mem_rdata, mem_wdata;
  int num_errors = 0, tests_run = 0;
  srrc_core dut (.*);
  srrc_partner pm (.*);
  always #50 aclk = ~aclk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    while (!bvalid);
    `chk(bresp, r)
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end
    while (!rvalid);
    `chk(rdata, d)
    `chk(rresp, r)
    rready <= 0;
  endtask
  task automatic ex(input logic [15:0] w, input int n);
    int c;
    @(posedge aclk);
    instr_word <= w;
    instr_valid <= 1;
    do @(posedge aclk); while (!instr_ready);
    instr_valid <= 0;
    c = 0;
    do
    begin
      @(posedge aclk);
      c++;
    end
    while (!instr_ready);
    `chk(c, n)
  endtask
  task automatic t_rot;
    wr(REG_BANK, 32'h2, RESP_OKAY);
    wr(REG_STATUS, 32'h0, RESP_OKAY);
    pm.mem[12'hF80] = 8'hE6;
    ex(16'h3480, 4);
    rd(REG_ACC, 32'hCC, RESP_OKAY);
    rd(REG_STATUS, 32'h11, RESP_OKAY);
    `chk(pm.mem[12'hF80], 8'hE6)
    pm.mem[12'h210] = 8'h80;
    ex(16'h3710, 4);
    `chk(pm.mem[12'h210], 8'h01)
    rd(REG_ACC, 32'hCC, RESP_OKAY);
    rd(REG_STATUS, 32'h01, RESP_OKAY);
  endtask
  task automatic t_idx;
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    wr(REG_IBASE, 32'h300, RESP_OKAY);
    wr(REG_STATUS, 32'h0, RESP_OKAY);
    pm.mem[12'h305] = 8'h80;
    ex(16'h3605, 4);
    `chk(pm.mem[12'h305], 8'h00)
    rd(REG_STATUS, 32'h05, RESP_OKAY);
  endtask
  task automatic t_ret;
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(REG_PC, 32'h1, RESP_SLVERR);
    wr(REG_WSHAD, 32'h5A, RESP_OKAY);
    wr(REG_FSHAD, 32'h12, RESP_OKAY);
    wr(REG_BSHAD, 32'h3, RESP_OKAY);
    wr(REG_PCH, 32'h44, RESP_OKAY);
    wr(REG_PCU, 32'h7, RESP_OKAY);
    pm.stk[0] = 21'h01234;
    pm.stk[1] = 21'h0ABCD;
    ex(16'h0012, 8);
    `chk(pc, 21'h01234)
    rd(REG_STATUS, 32'h05, RESP_OKAY);
    rd(REG_BANK, 32'h2, RESP_OKAY);
    rd(REG_ACC, 32'hCC, RESP_OKAY);
    ex(16'h0013, 8);
    `chk(pc, 21'h0ABCD)
    rd(REG_ACC, 32'h5A, RESP_OKAY);
    rd(REG_STATUS, 32'h12, RESP_OKAY);
    rd(REG_BANK, 32'h3, RESP_OKAY);
    rd(REG_PCH, 32'h44, RESP_OKAY);
    rd(REG_PCU, 32'h7, RESP_OKAY);
    rd(REG_PC, 32'h0ABCD, RESP_OKAY);
  endtask
  task automatic t_unk;
    ex(16'hFFFF, 1);
    rd(REG_INFO, 32'h101, RESP_OKAY);
    wr(REG_INFO, 32'h100, RESP_OKAY);
    rd(REG_INFO, 32'h1, RESP_OKAY);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    t_rot;
    t_idx;
    t_ret;
    t_unk;
    complete_run;
  end
  initial
  begin
    #2000000;
    num_errors++;
    complete_run;
  end
endmodule // subroutine_return_and_rotate_carry_tb
